// file: pkg/wesp_pkg.sv
// Constants shared by the wake event status and enable block.
package wesp_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] WESP_IDX_MASTER   = 6'h02;
    localparam logic [5:0] WESP_IDX_STS_ONE  = 6'h04;
    localparam logic [5:0] WESP_IDX_STS_TWO  = 6'h05;
    localparam logic [5:0] WESP_IDX_STS_FOUR = 6'h07;
    localparam logic [5:0] WESP_IDX_STS_FIVE = 6'h08;
    localparam logic [5:0] WESP_IDX_RSVD_NINE = 6'h09;
    localparam logic [5:0] WESP_IDX_EN_ONE   = 6'h0a;
    localparam logic [5:0] WESP_IDX_EN_TWO   = 6'h0b;
    localparam logic [5:0] WESP_IDX_IRQ_STS  = 6'h10;
    localparam logic [5:0] WESP_IDX_IRQ_MASK = 6'h11;

    // Byte address field of the Wishbone address.
    localparam int WESP_ADR_W   = 8;
    localparam int WESP_IDX_LSB = 2;

    // Reset values, applied on the standby power-on reset only.
    localparam logic [7:0]  WESP_RST_BYTE   = 8'h00;
    localparam logic [31:0] WESP_RST_WORD   = 32'h0000_0000;
    localparam logic        WESP_RST_MASTER = 1'b0;
    localparam logic [1:0]  WESP_RST_IRQ    = 2'h0;
    localparam logic        WESP_RST_WAKE_N = 1'b1;

    // Field positions.
    localparam int WESP_BIT_MASTER    = 0;
    localparam int WESP_BIT_INFRARED  = 0;
    localparam int WESP_BIT_RING_TWO  = 1;
    localparam int WESP_BIT_RING_ONE  = 2;
    localparam int WESP_BIT_KEYBOARD  = 3;
    localparam int WESP_BIT_MOUSE     = 4;
    localparam int WESP_BIT_SPEC_KEY  = 5;
    localparam int WESP_BIT_FAN_ONE   = 6;
    localparam int WESP_BIT_FAN_TWO   = 7;
    localparam int WESP_BIT_IRQ_WAKE  = 0;
    localparam int WESP_BIT_IRQ_EVENT = 1;
    localparam int WESP_IRQ_W         = 2;

endpackage : wesp_pkg

// file: src/wesp_sticky_bits.sv
// Sticky status bits: set by events, cleared by writing ones.
`timescale 1ns/10ps
module wesp_sticky_bits
    import wesp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    // Events and software clear.
    input  wire logic [WIDTH-1:0] i_set,
    input  wire logic             i_clr_en,
    input  wire logic [WIDTH-1:0] i_clr_bits,
    // Stored bits.
    output logic      [WIDTH-1:0] o_bits
);

    logic [WIDTH-1:0] bits_reg;
    logic [WIDTH-1:0] bits_next;

    // An event in the cycle of a clear keeps its bit set.
    always_comb begin
        bits_next = bits_reg;
        if (i_clr_en) begin
            bits_next = bits_reg & ~i_clr_bits;
        end
        bits_next = bits_next | i_set;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bits_reg <= {WIDTH{1'b0}};
        end else begin
            bits_reg <= bits_next;
        end
    end

    assign o_bits = bits_reg;

    AST_SET_WINS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_set != {WIDTH{1'b0}}) |=> ((o_bits & $past(i_set)) == $past(i_set)))
        else $error("event lost while clearing");

    AST_ZERO_KEEPS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_clr_en && i_clr_bits == {WIDTH{1'b0}})
        |=> ((o_bits & $past(o_bits)) == $past(o_bits)))
        else $error("writing zero changed a status bit");

endmodule : wesp_sticky_bits

// file: src/wesp_wake_ctrl.sv
// Wake event status and enable logic with a Wishbone register slave.
`timescale 1ns/10ps
module wesp_wake_ctrl
    import wesp_pkg::*;
(
    // Clock and standby power-on reset.
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,
    // Wishbone classic slave.
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [WESP_ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic [31:0]           i_wb_dat,
    output logic      [31:0]           o_wb_dat,
    output logic                       o_wb_ack,
    // Peripheral wake sources.
    input  wire logic                  i_consumer_infrared_wake,
    input  wire logic                  i_second_serial_ring_wake,
    input  wire logic                  i_first_serial_ring_wake,
    input  wire logic                  i_keyboard_wake,
    input  wire logic                  i_mouse_wake,
    input  wire logic                  i_specific_key_wake,
    input  wire logic                  i_first_fan_speed_wake,
    input  wire logic                  i_second_fan_speed_wake,
    // Pin wake sources.
    input  wire logic [7:0]            i_pin_wake_two,
    input  wire logic [7:0]            i_pin_wake_four,
    input  wire logic [7:0]            i_pin_wake_five,
    // Wake request and interrupt.
    output logic                       o_wake_request_out_n,
    output logic                       o_irq
);

    // Bus decode.
    logic        req;
    logic        acc;
    logic        wr;
    logic [5:0]  idx;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic [7:0]  rd_next;

    // Register state.
    logic [7:0]  evt_one;
    logic [7:0]  st_one;
    logic [7:0]  st_two;
    logic [7:0]  st_four;
    logic [7:0]  st_five;
    logic [7:0]  en_one_reg;
    logic [7:0]  en_two_reg;
    logic        master_reg;
    logic [WESP_IRQ_W-1:0] irq_sts;
    logic [WESP_IRQ_W-1:0] irq_evt;
    logic [WESP_IRQ_W-1:0] irq_mask_reg;
    logic        irq_reg;

    // Wake qualification.
    logic        wake_any;
    logic        wake_n_reg;

    assign req = i_wb_cyc & i_wb_stb;
    assign idx = i_wb_adr[WESP_ADR_W-1:WESP_IDX_LSB];
    // Writes take effect on the edge where the master sees the acknowledge.
    assign acc = req & ack_reg;
    assign wr  = acc & i_wb_we & i_wb_sel[0];

    // Source bits in the order of the first status and enable pair.
    always_comb begin
        evt_one = 8'h00;
        evt_one[WESP_BIT_INFRARED] = i_consumer_infrared_wake;
        evt_one[WESP_BIT_RING_TWO] = i_second_serial_ring_wake;
        evt_one[WESP_BIT_RING_ONE] = i_first_serial_ring_wake;
        evt_one[WESP_BIT_KEYBOARD] = i_keyboard_wake;
        evt_one[WESP_BIT_MOUSE]    = i_mouse_wake;
        evt_one[WESP_BIT_SPEC_KEY] = i_specific_key_wake;
        evt_one[WESP_BIT_FAN_ONE]  = i_first_fan_speed_wake;
        evt_one[WESP_BIT_FAN_TWO]  = i_second_fan_speed_wake;
    end

    // Status latches take every event, whatever the enables say.
    wesp_sticky_bits #(.WIDTH(8)) u_sts_one (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_set      (evt_one),
        .i_clr_en   (wr && idx == WESP_IDX_STS_ONE),
        .i_clr_bits (i_wb_dat[7:0]),
        .o_bits     (st_one)
    );

    wesp_sticky_bits #(.WIDTH(8)) u_sts_two (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_set      (i_pin_wake_two),
        .i_clr_en   (wr && idx == WESP_IDX_STS_TWO),
        .i_clr_bits (i_wb_dat[7:0]),
        .o_bits     (st_two)
    );

    wesp_sticky_bits #(.WIDTH(8)) u_sts_four (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_set      (i_pin_wake_four),
        .i_clr_en   (wr && idx == WESP_IDX_STS_FOUR),
        .i_clr_bits (i_wb_dat[7:0]),
        .o_bits     (st_four)
    );

    wesp_sticky_bits #(.WIDTH(8)) u_sts_five (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_set      (i_pin_wake_five),
        .i_clr_en   (wr && idx == WESP_IDX_STS_FIVE),
        .i_clr_bits (i_wb_dat[7:0]),
        .o_bits     (st_five)
    );

    // Enables and the master enable clear only on the standby reset.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            en_one_reg <= WESP_RST_BYTE;
            en_two_reg <= WESP_RST_BYTE;
        end else if (wr && idx == WESP_IDX_EN_ONE) begin
            en_one_reg <= i_wb_dat[7:0];
        end else if (wr && idx == WESP_IDX_EN_TWO) begin
            en_two_reg <= i_wb_dat[7:0];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            master_reg <= WESP_RST_MASTER;
        end else if (wr && idx == WESP_IDX_MASTER) begin
            master_reg <= i_wb_dat[WESP_BIT_MASTER];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            irq_mask_reg <= WESP_RST_IRQ;
        end else if (wr && idx == WESP_IDX_IRQ_MASK) begin
            irq_mask_reg <= i_wb_dat[WESP_IRQ_W-1:0];
        end
    end

    // A source wakes only with its status, its enable and the master set.
    assign wake_any = master_reg
        & (|((st_one & en_one_reg) | (st_two & en_two_reg)));

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wake_n_reg <= WESP_RST_WAKE_N;
        end else begin
            wake_n_reg <= ~wake_any;
        end
    end

    assign o_wake_request_out_n = wake_n_reg;

    // Interrupt events: a new wake request, and any source event.
    always_comb begin
        irq_evt = WESP_RST_IRQ;
        irq_evt[WESP_BIT_IRQ_WAKE]  = wake_any & wake_n_reg;
        irq_evt[WESP_BIT_IRQ_EVENT] = |{evt_one, i_pin_wake_two,
                                        i_pin_wake_four, i_pin_wake_five};
    end

    wesp_sticky_bits #(.WIDTH(WESP_IRQ_W)) u_irq_sts (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_set      (irq_evt),
        .i_clr_en   (wr && idx == WESP_IDX_IRQ_STS),
        .i_clr_bits (i_wb_dat[WESP_IRQ_W-1:0]),
        .o_bits     (irq_sts)
    );

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_sts & irq_mask_reg);
        end
    end

    assign o_irq = irq_reg;

    // Read mux; reserved and unmapped slots read as zero.
    always_comb begin
        rd_next = WESP_RST_BYTE;
        case (idx)
            WESP_IDX_MASTER: begin
                rd_next[WESP_BIT_MASTER] = master_reg;
            end
            WESP_IDX_STS_ONE: begin
                rd_next = st_one;
            end
            WESP_IDX_STS_TWO: begin
                rd_next = st_two;
            end
            WESP_IDX_STS_FOUR: begin
                rd_next = st_four;
            end
            WESP_IDX_STS_FIVE: begin
                rd_next = st_five;
            end
            WESP_IDX_RSVD_NINE: begin
                rd_next = WESP_RST_BYTE;
            end
            WESP_IDX_EN_ONE: begin
                rd_next = en_one_reg;
            end
            WESP_IDX_EN_TWO: begin
                rd_next = en_two_reg;
            end
            WESP_IDX_IRQ_STS: begin
                rd_next[WESP_IRQ_W-1:0] = irq_sts;
            end
            WESP_IDX_IRQ_MASK: begin
                rd_next[WESP_IRQ_W-1:0] = irq_mask_reg;
            end
            default: begin
                rd_next = WESP_RST_BYTE;
            end
        endcase
    end

    // One wait state: acknowledge one cycle after the request, one cycle long.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            dat_reg <= WESP_RST_WORD;
        end else if (req && !ack_reg) begin
            dat_reg <= {24'h00_0000, rd_next};
        end
    end

    assign o_wb_ack = ack_reg;
    assign o_wb_dat = dat_reg;

    default clocking cb_sys @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence seq_read_nine;
        req && !ack_reg && !i_wb_we && idx == WESP_IDX_RSVD_NINE;
    endsequence

    sequence seq_write_en_two;
        wr && idx == WESP_IDX_EN_TWO;
    endsequence

    sequence seq_clear_keyboard;
        wr && idx == WESP_IDX_STS_ONE && i_wb_dat[WESP_BIT_KEYBOARD]
            && !i_keyboard_wake;
    endsequence

    AST_STS_IGNORES_ENABLE: assert property (
        (i_keyboard_wake && !en_one_reg[WESP_BIT_KEYBOARD] && !master_reg)
        |=> st_one[WESP_BIT_KEYBOARD])
        else $error("disabled source did not latch");

    AST_STS_HOLDS: assert property (
        (st_two[0] && !(wr && idx == WESP_IDX_STS_TWO && i_wb_dat[0]))
        |=> st_two[0])
        else $error("status bit dropped without a clear");

    AST_W1C_CLEARS: assert property (
        seq_clear_keyboard |=> !st_one[WESP_BIT_KEYBOARD])
        else $error("write one did not clear status");

    AST_WAKE_ASSERTS: assert property (
        (master_reg && (st_one[WESP_BIT_MOUSE] && en_one_reg[WESP_BIT_MOUSE]))
        |=> !o_wake_request_out_n)
        else $error("qualified source did not wake");

    AST_DISABLED_NO_WAKE: assert property (
        (en_one_reg == 8'h00 && en_two_reg == 8'h00)
        |=> o_wake_request_out_n)
        else $error("wake asserted with all enables off");

    AST_MASTER_GATES: assert property (
        !master_reg |=> o_wake_request_out_n)
        else $error("wake asserted with master off");

    AST_WAKE_RELEASES: assert property (
        (!o_wake_request_out_n && !wake_any) |=> o_wake_request_out_n)
        else $error("wake not released");

    AST_STS_FOUR_MAP: assert property (
        i_pin_wake_four[7] |=> st_four[7])
        else $error("status four bit seven not set");

    AST_STS_FIVE_MAP: assert property (
        i_pin_wake_five[0] |=> st_five[0])
        else $error("status five bit zero not set");

    AST_RSVD_NINE_ZERO: assert property (
        seq_read_nine ##1 o_wb_ack |-> o_wb_dat == WESP_RST_WORD)
        else $error("reserved slot read nonzero");

    AST_EN_TWO_WRITE: assert property (
        seq_write_en_two |=> en_two_reg == 8'($past(i_wb_dat)))
        else $error("enable two write lost");

    AST_ACK_ONE_CYCLE: assert property (
        (req && !ack_reg) |=> o_wb_ack ##1 !o_wb_ack)
        else $error("acknowledge not a single cycle");

endmodule : wesp_wake_ctrl

// file: tb/wesp_pm_partner.sv
// Power-management model that counts wake requests from the block.
`timescale 1ns/10ps
module wesp_pm_partner (
    // Clock, reset and wake request.
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_wake_request_out_n,
    // Number of wake requests seen.
    output int        o_wake_count
);
    logic prev_reg;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prev_reg     <= 1'b1;
            o_wake_count <= 0;
        end else begin
            prev_reg <= i_wake_request_out_n;
            if (prev_reg && !i_wake_request_out_n) begin
                o_wake_count <= o_wake_count + 1;
            end
        end
    end
endmodule : wesp_pm_partner

// file: tb/tb.sv
// Self-checking bench for the wake event status and enable block.
`timescale 1ns/10ps
module tb;
    import wesp_pkg::*;
    localparam logic [5:0] RIDX [12] = '{WESP_IDX_MASTER, WESP_IDX_STS_ONE,
        WESP_IDX_STS_TWO, WESP_IDX_STS_FOUR, WESP_IDX_STS_FIVE,
        WESP_IDX_RSVD_NINE, WESP_IDX_EN_ONE, WESP_IDX_EN_TWO,
        WESP_IDX_IRQ_STS, WESP_IDX_IRQ_MASK, 6'h06, 6'h3f};
    logic        clk, rst, cyc, stb, we, ack, wake_n, irq;
    logic [7:0]  adr, per_ev, pin2, pin4, pin5, lfsr_reg;
    logic [3:0]  sel;
    logic [31:0] wdat, odat, rdat;
    int          n_errors, check_count, wakes, exp_wakes, prev_w, k;
    int          m_sts [4];
    int          m_en1, m_en2, m_mst, m_irs, m_irm;

    wesp_wake_ctrl dut_u (
        .i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(odat), .o_wb_ack(ack),
        .i_consumer_infrared_wake(per_ev[0]),
        .i_second_serial_ring_wake(per_ev[1]),
        .i_first_serial_ring_wake(per_ev[2]),
        .i_keyboard_wake(per_ev[3]), .i_mouse_wake(per_ev[4]),
        .i_specific_key_wake(per_ev[5]),
        .i_first_fan_speed_wake(per_ev[6]),
        .i_second_fan_speed_wake(per_ev[7]),
        .i_pin_wake_two(pin2), .i_pin_wake_four(pin4),
        .i_pin_wake_five(pin5), .o_wake_request_out_n(wake_n),
        .o_irq(irq));

    wesp_pm_partner pm_u (.i_clk_sys(clk), .i_rst(rst),
        .i_wake_request_out_n(wake_n), .o_wake_count(wakes));

    function automatic logic [7:0] rnd();
        lfsr_reg = {lfsr_reg[6:0],
                    lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
        return lfsr_reg;
    endfunction : rnd

    function automatic int mval(input logic [5:0] idx);
        case (idx)
            WESP_IDX_MASTER:   return m_mst;
            WESP_IDX_STS_ONE:  return m_sts[0];
            WESP_IDX_STS_TWO:  return m_sts[1];
            WESP_IDX_STS_FOUR: return m_sts[2];
            WESP_IDX_STS_FIVE: return m_sts[3];
            WESP_IDX_EN_ONE:   return m_en1;
            WESP_IDX_EN_TWO:   return m_en2;
            WESP_IDX_IRQ_STS:  return m_irs;
            WESP_IDX_IRQ_MASK: return m_irm;
            default:           return 0;
        endcase
    endfunction : mval

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb(input logic w, input logic [5:0] idx,
                      input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= s;
        adr  <= {idx, 2'b00};
        wdat <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = odat;
        cyc <= 1'b0;
        stb <= 1'b0;
        check({31'h0000_0000, ack}, 32'h0000_0001);
    endtask : wb

    // Waits for outputs to follow, then compares them with the model.
    task automatic settle();
        int w;
        repeat (5) @(posedge clk);
        w = (m_mst != 0) && (((m_sts[0] & m_en1) | (m_sts[1] & m_en2)) != 0);
        if (w != 0 && prev_w == 0) begin
            m_irs |= 1;
            exp_wakes++;
        end
        prev_w = w;
        #1;
        check({31'h0000_0000, wake_n}, 32'(w == 0));
        check({31'h0000_0000, irq}, 32'((m_irs & m_irm) != 0));
        check(wakes, exp_wakes);
    endtask : settle

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 4'hf);
        case (idx)
            WESP_IDX_MASTER:   m_mst = d[0];
            WESP_IDX_STS_ONE:  m_sts[0] &= ~d;
            WESP_IDX_STS_TWO:  m_sts[1] &= ~d;
            WESP_IDX_STS_FOUR: m_sts[2] &= ~d;
            WESP_IDX_STS_FIVE: m_sts[3] &= ~d;
            WESP_IDX_EN_ONE:   m_en1 = d;
            WESP_IDX_EN_TWO:   m_en2 = d;
            WESP_IDX_IRQ_STS:  m_irs &= ~d;
            WESP_IDX_IRQ_MASK: m_irm = d & 3;
            default:           m_irm = m_irm;
        endcase
        settle();
    endtask : wr

    task automatic read_all();
        for (int i = 0; i < 12; i++) begin
            wb(1'b0, RIDX[i], rnd(), 4'hf);
            check(rdat, mval(RIDX[i]));
        end
    endtask : read_all

    // One-cycle pulse on every source group with random bits.
    task automatic ev();
        logic [7:0] a, b, c, e;
        a = rnd();
        b = rnd();
        c = rnd();
        e = rnd();
        @(posedge clk);
        per_ev <= a;
        pin2   <= b;
        pin4   <= c;
        pin5   <= e;
        @(posedge clk);
        per_ev <= 8'h00;
        pin2   <= 8'h00;
        pin4   <= 8'h00;
        pin5   <= 8'h00;
        m_sts = '{m_sts[0] | a, m_sts[1] | b, m_sts[2] | c, m_sts[3] | e};
        if ((a | b | c | e) != 0) m_irs |= 2;
        settle();
    endtask : ev

    task automatic model_reset();
        m_sts = '{0, 0, 0, 0};
        {m_en1, m_en2, m_mst, m_irs, m_irm, prev_w, exp_wakes} = '0;
    endtask : model_reset

    task automatic complete_run();
        $display("Errors %0d, checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #200000;
        n_errors++;
        complete_run();
    end

    initial begin
        {rst, cyc, stb, we, sel, adr, wdat} = '0;
        {per_ev, pin2, pin4, pin5, n_errors, check_count} = '0;
        rst = 1'b1;
        lfsr_reg = 8'h2a;
        model_reset();
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        read_all();
        settle();
        wb(1'b1, WESP_IDX_EN_ONE, 8'hff, 4'he);
        read_all();
        for (k = 0; k < 14; k++) begin
            wr(WESP_IDX_IRQ_MASK, rnd());
            wr(WESP_IDX_EN_ONE, rnd());
            wr(WESP_IDX_EN_TWO, rnd());
            wr(WESP_IDX_MASTER, (k < 3) ? 8'h00 : rnd());
            ev();
            read_all();
            wr(WESP_IDX_STS_ONE, rnd());
            wr(WESP_IDX_STS_TWO, rnd());
            wr(WESP_IDX_STS_FOUR, rnd());
            wr(WESP_IDX_STS_FIVE, rnd());
            wr(WESP_IDX_RSVD_NINE, rnd());
            wr(6'h3f, rnd());
            read_all();
            wr(WESP_IDX_IRQ_STS, rnd());
        end
        // A keyboard event held through a clear keeps its status bit set.
        @(posedge clk);
        per_ev <= 8'h08;
        wb(1'b1, WESP_IDX_STS_ONE, 8'h08, 4'hf);
        wb(1'b0, WESP_IDX_STS_ONE, 8'h00, 4'hf);
        check(rdat & 32'h0000_0008, 32'h0000_0008);
        per_ev <= 8'h00;
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        model_reset();
        read_all();
        settle();
        complete_run();
    end
endmodule : tb
